/* sfp_chk.sv */
/* checker for the packer frame and session ports
   assumes binding into sfp_packer */
`timescale 1ns/1ps
module sfp_chk (
   input wire logic        REF_CLK,
   input wire logic        NRST,
   input wire logic        RX_READY,
   input wire logic [7:0]  TX_DATA,
   input wire logic        TX_VALID,
   input wire logic        TX_LAST,
   input wire logic        TX_READY,
   input wire logic        SESSION_OPEN,
   input wire logic        SES_OPEN_REQ,
   input wire logic        SES_CLOSE_REQ,
   input wire logic [15:0] UDP_PORT
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!NRST);
   // handover steps of a frame
   sequence stall; TX_VALID && !TX_READY; endsequence
   sequence frame_end; TX_VALID && TX_READY && TX_LAST; endsequence
   chk_tx_hold: assert property (stall |=> TX_VALID && $stable({TX_DATA, TX_LAST}))
      else $error("frame byte moved");
   chk_last_end: assert property (frame_end |=> !TX_VALID)
      else $error("frame runs on");
   chk_rx_back: assert property (frame_end |=> RX_READY)
      else $error("serial side not reopened");
   chk_rx_drain: assert property (TX_VALID |-> !RX_READY)
      else $error("bytes taken while draining");
   chk_flush_first: assert property ($rose(TX_VALID) |-> !$past(RX_READY))
      else $error("frame without flush");
   chk_udp_port: assert property (UDP_PORT != 16'h0000)
      else $error("listen port zero");
   chk_open_req: assert property (SES_OPEN_REQ |-> SESSION_OPEN)
      else $error("open request, session shut");
   chk_close_req: assert property (SES_CLOSE_REQ |-> !SESSION_OPEN)
      else $error("close request, session open");
   chk_open_pulse: assert property (SES_OPEN_REQ |=> !SES_OPEN_REQ)
      else $error("open request too long");
endmodule : sfp_chk
bind sfp_packer sfp_chk u_chk (.*);

/* sfp_net_sink.sv */
/* network side model: collects frame bytes
   assumes the packer transmit handshake */
`timescale 1ns/1ps
module sfp_net_sink (
   input wire logic       REF_CLK,
   input wire logic [7:0] TX_DATA,
   input wire logic       TX_VALID,
   input wire logic       slow,
   output logic           TX_READY = 1'b0
);
   logic [7:0] got[$];
   logic       ph = 1'b0;
   // a slow session grants every other cycle and holds the others back
   always @(posedge REF_CLK)
   begin
      if (TX_VALID && TX_READY) got.push_back(TX_DATA);
      ph <= !ph;
      TX_READY <= !slow || ph;
   end
endmodule : sfp_net_sink

/* sfp_packer.sv */
/*
 * Serial frame packer: collects bytes from a serial receiver into a
 * frame buffer, flushes frames to the network transmit path on length,
 * delimiter, timeout or full-buffer conditions, and decides when a
 * network session is opened or closed. Registers on AXI4-Lite.
 * Assumes all inputs synchronous to REF_CLK and a network side that
 * takes frame bytes with a valid/ready handshake.
 */
// Functional notes
// R01: packing length zero means byte count never ends a frame.
// R02: nonzero packing length flushes when buffered count equals it.
// R03: receiving both delimiter bytes flushes the whole buffer at once.
// R04: plus-one / plus-two modes flush after one / two extra bytes.
// R05: strip mode drops delimiter bytes from the flushed frame.
// R06: default mode flushes including the delimiter when it is seen.
// R07: flush timeout of zero ms disables timer flushing.
// R08: nonzero timeout flushes bytes gathered once the interval expires.
// R09: buffer reaching one kilobyte always forces a flush.
// R10: with only the first delimiter enabled, it alone triggers flush.
// R11: software must enable the first delimiter for delimiter flushing.
// R12: startup mode opens a session after reset and never closes it.
// R13: character modes open on any received byte; stay open otherwise.
// R14: any-character/inactivity mode closes after the idle interval.
// R15: DSR modes open on DSR on; close on off only if selected.
// R16: DCD modes open on DCD on; close on off only if selected.
// R17: inactivity timer only counts in the any-character mode.
// R18: software should set inactivity longer than the flush timeout.
// R19: frames go to up to four sessions; a slow one stalls all.
// R20: datagram mode listens on a local port 1..65535, default 4001.
// R21: coincident flush conditions yield one frame and restart counting.
`timescale 1ns/1ps
module sfp_packer #(
   parameter int unsigned DEPTH     = sfp_pkg::FRAME_MAX,
   parameter int unsigned MS_CYCLES = sfp_pkg::MS_CYCLES
) (
   // clock and reset
   input  wire logic        REF_CLK,
   input  wire logic        NRST,
   // axi4-lite write
   input  wire logic [7:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   // axi4-lite read
   input  wire logic [7:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   // serial receive side
   input  wire logic [7:0]  RX_DATA,
   input  wire logic        RX_VALID,
   output logic             RX_READY,
   input  wire logic        DSR,
   input  wire logic        DCD,
   // network transmit side
   output logic [7:0]       TX_DATA,
   output logic             TX_VALID,
   output logic             TX_LAST,
   input  wire logic        TX_READY,
   output logic [3:0]       TX_SESS,
   // session control
   output logic             SESSION_OPEN,
   output logic             SES_OPEN_REQ,
   output logic             SES_CLOSE_REQ,
   output logic             UDP_MODE,
   output logic [15:0]      UDP_PORT
);

   localparam int unsigned AW = $clog2(DEPTH);

   // refuse sizes the counters cannot serve
   if (DEPTH < 4 || DEPTH > sfp_pkg::FRAME_MAX) begin : g_depth_chk
      $error("sfp_packer: DEPTH out of range");
   end
   if (MS_CYCLES < 1) begin : g_ms_chk
      $error("sfp_packer: MS_CYCLES must be at least one");
   end

   typedef enum logic {ST_COLLECT, ST_DRAIN} sfp_state_t;

   // ***************************************************************
   // helpers
   // ***************************************************************
   function automatic logic [31:0] sfp_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
            res[8*i +: 8] = new_v[8*i +: 8];
      end
      return res;
   endfunction : sfp_merge

   function automatic logic sfp_mapped(input logic [7:0] addr);
      return addr[1:0] == 2'h0 && addr <= sfp_pkg::ADDR_FRAMES;
   endfunction : sfp_mapped

   // ***************************************************************
   // registers and state
   // ***************************************************************
   logic [31:0]                 ctrl;
   logic [15:0]                 delim;
   logic [sfp_pkg::CNT_W-1:0]   pack_len;
   logic [sfp_pkg::MS_W-1:0]    force_ms;
   logic [sfp_pkg::MS_W-1:0]    inact_ms;
   logic [15:0]                 frame_cnt;
   logic                        aw_held;
   logic                        w_held;
   logic [7:0]                  aw_addr;
   logic [31:0]                 w_data;
   logic [3:0]                  w_strb;
   logic                        do_write;
   logic [31:0]                 wr_val;

   sfp_state_t                  state;
   logic [7:0]                  mem [DEPTH];
   logic [sfp_pkg::CNT_W-1:0]   cnt;
   logic [sfp_pkg::CNT_W-1:0]   flen;
   logic [sfp_pkg::CNT_W-1:0]   rd_ptr;
   logic                        d1_seen;
   logic [1:0]                  extra_left;
   logic [31:0]                 ms_div;
   logic                        ms_tick;
   logic [sfp_pkg::MS_W-1:0]    elapsed;
   logic [sfp_pkg::MS_W-1:0]    idle;

   sfp_pkg::sfp_dproc_t         dproc;
   sfp_pkg::sfp_cmode_t         cmode;
   logic                        d1_en;
   logic                        d2_en;
   logic                        rx_take;
   logic                        delim_hit;
   logic                        flush_any;
   logic [sfp_pkg::CNT_W-1:0]   new_cnt;
   logic [sfp_pkg::CNT_W-1:0]   next_flen;
   logic [sfp_pkg::CNT_W-1:0]   ndel;
   logic                        next_open;

   assign dproc    = sfp_pkg::sfp_dproc_t'(ctrl[sfp_pkg::CTRL_DPROC_LSB +: 2]);
   assign cmode    = sfp_pkg::sfp_cmode_t'(ctrl[sfp_pkg::CTRL_CMODE_LSB +: 3]);
   assign d1_en    = ctrl[sfp_pkg::CTRL_D1EN];
   assign d2_en    = ctrl[sfp_pkg::CTRL_D2EN];
   assign TX_SESS  = ctrl[sfp_pkg::CTRL_SMASK_LSB +: sfp_pkg::NUM_SESS]; // [R19]
   assign UDP_MODE = ctrl[sfp_pkg::CTRL_UDP];
   assign do_write = aw_held && w_held && !S_AXI_BVALID;
   assign wr_val   = sfp_merge(32'h0, w_data, w_strb);

   // ***************************************************************
   // axi4-lite write channel
   // ***************************************************************
   // address and data are taken in either order, one write at a time
   always_ff @(posedge REF_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         S_AXI_AWREADY <= 1'b1;
         S_AXI_WREADY  <= 1'b1;
         S_AXI_BVALID  <= 1'b0;
         S_AXI_BRESP   <= sfp_pkg::RESP_OKAY;
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= 8'h00;
         w_data        <= 32'h0000_0000;
         w_strb        <= 4'h0;
      end
      else
      begin
         if (S_AXI_AWVALID && S_AXI_AWREADY)
         begin
            aw_held       <= 1'b1;
            aw_addr       <= S_AXI_AWADDR;
            S_AXI_AWREADY <= 1'b0;
         end
         if (S_AXI_WVALID && S_AXI_WREADY)
         begin
            w_held       <= 1'b1;
            w_data       <= S_AXI_WDATA;
            w_strb       <= S_AXI_WSTRB;
            S_AXI_WREADY <= 1'b0;
         end
         if (do_write)
         begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= sfp_mapped(aw_addr) ? sfp_pkg::RESP_OKAY : sfp_pkg::RESP_DECERR;
         end
         if (S_AXI_BVALID && S_AXI_BREADY)
         begin
            S_AXI_BVALID  <= 1'b0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY  <= 1'b1;
         end
      end
   end

   // register file; status and frame count are read only
   always_ff @(posedge REF_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         ctrl     <= sfp_pkg::CTRL_RST;
         delim    <= 16'h0000;
         pack_len <= '0;
         force_ms <= '0;
         inact_ms <= '0;
         UDP_PORT <= sfp_pkg::UDP_PORT_RST;                          // [R20]
      end
      else if (do_write)
      begin
         unique case (aw_addr)
            sfp_pkg::ADDR_CTRL:  ctrl     <= sfp_merge(ctrl, w_data, w_strb);
            sfp_pkg::ADDR_DELIM: delim    <= 16'(sfp_merge({16'h0, delim}, w_data, w_strb));
            sfp_pkg::ADDR_PACK:
            begin
               // lengths above the buffer size are clamped to a full buffer
               if (wr_val[sfp_pkg::CNT_W-1:0] > sfp_pkg::CNT_W'(DEPTH))
                  pack_len <= sfp_pkg::CNT_W'(DEPTH);
               else
                  pack_len <= wr_val[sfp_pkg::CNT_W-1:0];
            end
            sfp_pkg::ADDR_FORCE: force_ms <= 16'(sfp_merge({16'h0, force_ms}, w_data, w_strb));
            sfp_pkg::ADDR_INACT: inact_ms <= 16'(sfp_merge({16'h0, inact_ms}, w_data, w_strb));
            sfp_pkg::ADDR_UDP:
            begin
               // port zero is not a legal listen port, keep the old one
               if (sfp_merge({16'h0, UDP_PORT}, w_data, w_strb) != 32'h0) // [R20]
                  UDP_PORT <= 16'(sfp_merge({16'h0, UDP_PORT}, w_data, w_strb));
            end
            default: ;
         endcase
      end
   end

   // ***************************************************************
   // axi4-lite read channel
   // ***************************************************************
   // one-cycle read latency from the address handshake
   always_ff @(posedge REF_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         S_AXI_ARREADY <= 1'b1;
         S_AXI_RVALID  <= 1'b0;
         S_AXI_RDATA   <= 32'h0000_0000;
         S_AXI_RRESP   <= sfp_pkg::RESP_OKAY;
      end
      else if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID  <= 1'b1;
         S_AXI_RRESP   <= sfp_mapped(S_AXI_ARADDR) ? sfp_pkg::RESP_OKAY : sfp_pkg::RESP_DECERR;
         unique case (S_AXI_ARADDR)
            sfp_pkg::ADDR_CTRL:   S_AXI_RDATA <= ctrl;
            sfp_pkg::ADDR_DELIM:  S_AXI_RDATA <= {16'h0, delim};
            sfp_pkg::ADDR_PACK:   S_AXI_RDATA <= {21'h0, pack_len};
            sfp_pkg::ADDR_FORCE:  S_AXI_RDATA <= {16'h0, force_ms};
            sfp_pkg::ADDR_INACT:  S_AXI_RDATA <= {16'h0, inact_ms};
            sfp_pkg::ADDR_UDP:    S_AXI_RDATA <= {16'h0, UDP_PORT};
            sfp_pkg::ADDR_STATUS: S_AXI_RDATA <= {12'h0, DCD, DSR, state == ST_DRAIN,
                                                  SESSION_OPEN, 5'h0, cnt};
            sfp_pkg::ADDR_FRAMES: S_AXI_RDATA <= {16'h0, frame_cnt};
            default:              S_AXI_RDATA <= 32'h0000_0000;
         endcase
      end
      else if (S_AXI_RVALID && S_AXI_RREADY)
      begin
         S_AXI_RVALID  <= 1'b0;
         S_AXI_ARREADY <= 1'b1;
      end
   end

   // ***************************************************************
   // flush decision
   // ***************************************************************
   // a pending plus-one/two tail masks new delimiters until it completes
   always_comb
   begin
      rx_take   = RX_VALID && RX_READY;
      new_cnt   = rx_take ? cnt + 1'b1 : cnt;
      ndel      = d2_en ? sfp_pkg::CNT_W'(2) : sfp_pkg::CNT_W'(1);
      // first delimiter is mandatory; second is optional       [R11]
      delim_hit = rx_take && extra_left == 2'h0 && d1_en &&
                  (d2_en ? (d1_seen && RX_DATA == delim[15:8])           // [R03]
                         : RX_DATA == delim[7:0]);                       // [R10]
      flush_any = 1'b0;
      if (delim_hit && (dproc == sfp_pkg::DP_NONE || dproc == sfp_pkg::DP_STRIP))
         flush_any = 1'b1;                                               // [R06]
      if (rx_take && extra_left == 2'h1)
         flush_any = 1'b1;                                               // [R04]
      if (rx_take && pack_len != '0 && new_cnt == pack_len)
         flush_any = 1'b1;                                               // [R01] [R02]
      if (new_cnt == sfp_pkg::CNT_W'(DEPTH))
         flush_any = 1'b1;                                               // [R09]
      if (force_ms != '0 && elapsed >= force_ms && new_cnt != '0)
         flush_any = 1'b1;                                               // [R07] [R08]
      next_flen = new_cnt;
      if (delim_hit && dproc == sfp_pkg::DP_STRIP)
         next_flen = (new_cnt > ndel) ? new_cnt - ndel : '0;             // [R05]
   end

   // ***************************************************************
   // collect and drain
   // ***************************************************************
   // receive stalls while a frame drains; trades throughput for no copy
   always_ff @(posedge REF_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         state      <= ST_COLLECT;
         RX_READY   <= 1'b1;
         cnt        <= '0;
         flen       <= '0;
         rd_ptr     <= '0;
         d1_seen    <= 1'b0;
         extra_left <= 2'h0;
         frame_cnt  <= 16'h0000;
         TX_VALID   <= 1'b0;
         TX_LAST    <= 1'b0;
         TX_DATA    <= 8'h00;
      end
      else
      begin
         unique case (state)
            ST_COLLECT:
            begin
               if (rx_take)
                  d1_seen <= d1_en && RX_DATA == delim[7:0];
               if (flush_any)
               begin
                  // one frame for all coincident conditions        [R21]
                  cnt        <= '0;
                  extra_left <= 2'h0;
                  flen       <= next_flen;
                  rd_ptr     <= '0;
                  if (next_flen != '0)
                  begin
                     state     <= ST_DRAIN;
                     RX_READY  <= 1'b0;
                     frame_cnt <= frame_cnt + 16'h0001;
                  end
               end
               else
               begin
                  cnt <= new_cnt;
                  if (delim_hit && dproc == sfp_pkg::DP_PLUS1)
                     extra_left <= 2'h1;                                 // [R04]
                  else if (delim_hit && dproc == sfp_pkg::DP_PLUS2)
                     extra_left <= 2'h2;                                 // [R04]
                  else if (rx_take && extra_left != 2'h0)
                     extra_left <= extra_left - 2'h1;
               end
            end
            ST_DRAIN:
            begin
               // one network stream feeds every enabled session    [R19]
               if (!TX_VALID || TX_READY)
               begin
                  if (rd_ptr < flen)
                  begin
                     TX_DATA  <= mem[rd_ptr[AW-1:0]];
                     TX_VALID <= 1'b1;
                     TX_LAST  <= rd_ptr == flen - 1'b1;
                     rd_ptr   <= rd_ptr + 1'b1;
                  end
                  else
                  begin
                     TX_VALID <= 1'b0;
                     TX_LAST  <= 1'b0;
                     state    <= ST_COLLECT;
                     RX_READY <= 1'b1;
                  end
               end
            end
         endcase
      end
   end

   // frame buffer storage, no reset needed
   always_ff @(posedge REF_CLK)
   begin
      if (rx_take)
         mem[cnt[AW-1:0]] <= RX_DATA;
   end

   // ***************************************************************
   // millisecond timing
   // ***************************************************************
   always_ff @(posedge REF_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         ms_div  <= 32'h0;
         ms_tick <= 1'b0;
      end
      else
      begin
         ms_tick <= ms_div == 32'(MS_CYCLES - 1);
         ms_div  <= (ms_div == 32'(MS_CYCLES - 1)) ? 32'h0 : ms_div + 32'h1;
      end
   end

   // flush interval runs from the first buffered byte; saturates
   always_ff @(posedge REF_CLK or negedge NRST)
   begin
      if (!NRST)
         elapsed <= '0;
      else if (flush_any || new_cnt == '0 || state == ST_DRAIN)
         elapsed <= '0;                                                  // [R21]
      else if (ms_tick && elapsed != '1)
         elapsed <= elapsed + 1'b1;                                      // [R08]
   end

   // idle time since the last received byte, any-character mode only
   always_ff @(posedge REF_CLK or negedge NRST)
   begin
      if (!NRST)
         idle <= '0;
      else if (rx_take || cmode != sfp_pkg::CM_ANY_INACT)
         idle <= '0;                                                     // [R17]
      else if (ms_tick && idle != '1)
         idle <= idle + 1'b1;
   end

   // ***************************************************************
   // session control
   // ***************************************************************
   always_comb
   begin
      next_open = SESSION_OPEN;
      unique case (cmode)
         sfp_pkg::CM_STARTUP:  next_open = 1'b1;                         // [R12]
         sfp_pkg::CM_ANY_NONE: next_open = SESSION_OPEN || rx_take;      // [R13]
         sfp_pkg::CM_ANY_INACT:
         begin
            if (rx_take)
               next_open = 1'b1;                                         // [R13]
            else if (inact_ms != '0 && idle >= inact_ms)
               next_open = 1'b0;                                         // [R14] [R18]
         end
         sfp_pkg::CM_DSR_OFF:  next_open = DSR;                          // [R15]
         sfp_pkg::CM_DSR_NONE: next_open = SESSION_OPEN || DSR;          // [R15]
         sfp_pkg::CM_DCD_OFF:  next_open = DCD;                          // [R16]
         sfp_pkg::CM_DCD_NONE: next_open = SESSION_OPEN || DCD;          // [R16]
         default:              next_open = 1'b1;   // spare code acts as startup
      endcase
   end

   // open and close requests are one-cycle pulses on each change
   always_ff @(posedge REF_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         SESSION_OPEN  <= 1'b0;
         SES_OPEN_REQ  <= 1'b0;
         SES_CLOSE_REQ <= 1'b0;
      end
      else
      begin
         SESSION_OPEN  <= next_open;
         SES_OPEN_REQ  <= next_open && !SESSION_OPEN;
         SES_CLOSE_REQ <= !next_open && SESSION_OPEN;
      end
   end

endmodule : sfp_packer

/* sfp_pkg.sv */
/*
 * Constants shared by the serial frame packer: register map, field
 * positions, reset values, mode encodings and timing figures.
 * Assumes a 250 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package sfp_pkg;

   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned MS_NS         = 1000000;
   localparam int unsigned MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

   // ***************************************************************
   // sizes
   // ***************************************************************
   localparam int unsigned FRAME_MAX = 1024;  // buffer bytes before forced flush
   localparam int unsigned CNT_W     = 11;    // holds 0..1024
   localparam int unsigned MS_W      = 16;    // 0..65535 ms settings
   localparam int unsigned NUM_SESS  = 4;     // simultaneous host sessions

   // ***************************************************************
   // register map (byte addresses)
   // ***************************************************************
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_DELIM  = 8'h04;
   localparam logic [7:0] ADDR_PACK   = 8'h08;
   localparam logic [7:0] ADDR_FORCE  = 8'h0c;
   localparam logic [7:0] ADDR_INACT  = 8'h10;
   localparam logic [7:0] ADDR_UDP    = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;
   localparam logic [7:0] ADDR_FRAMES = 8'h1c;

   // control field positions
   localparam int unsigned CTRL_DPROC_LSB = 0;   // 2 bits
   localparam int unsigned CTRL_D1EN      = 2;
   localparam int unsigned CTRL_D2EN      = 3;
   localparam int unsigned CTRL_CMODE_LSB = 4;   // 3 bits
   localparam int unsigned CTRL_UDP       = 7;
   localparam int unsigned CTRL_SMASK_LSB = 8;   // 4 bits
   localparam int unsigned STAT_OPEN      = 16;
   localparam int unsigned STAT_DRAIN     = 17;
   localparam int unsigned STAT_DSR       = 18;
   localparam int unsigned STAT_DCD       = 19;

   // reset values
   localparam logic [31:0] CTRL_RST     = 32'h0000_0100;
   localparam logic [15:0] UDP_PORT_RST = 16'h0fa1;    // 4001

   // bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // delimiter handling
   typedef enum logic [1:0] {DP_NONE, DP_PLUS1, DP_PLUS2, DP_STRIP} sfp_dproc_t;

   // connect / disconnect condition
   typedef enum logic [2:0] {
      CM_STARTUP, CM_ANY_NONE, CM_ANY_INACT, CM_DSR_OFF, CM_DSR_NONE,
      CM_DCD_OFF, CM_DCD_NONE, CM_SPARE
   } sfp_cmode_t;

endpackage : sfp_pkg

/* testbench.sv */
/* bench for sfp_packer: register, serial and session tests
   assumes the sink model and the bound checker */
`timescale 1ns/1ps
module testbench;
   logic REF_CLK = 0, NRST = 0, slow = 0, RX_VALID = 0, DSR = 0, DCD = 0;
   logic [7:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0, RX_DATA = 0, TX_DATA;
   logic [31:0] S_AXI_WDATA = 0, S_AXI_RDATA;
   logic [3:0] S_AXI_WSTRB = 4'hf, TX_SESS;
   logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
   logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_ARVALID = 0;
   logic S_AXI_BREADY = 1, S_AXI_RREADY = 1, S_AXI_AWREADY, S_AXI_WREADY;
   logic S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, RX_READY, TX_VALID, TX_LAST;
   logic TX_READY, SESSION_OPEN, SES_OPEN_REQ, SES_CLOSE_REQ, UDP_MODE;
   logic [15:0] UDP_PORT;
   int error_cnt = 0;
   int comparisons = 0;
   // small buffer and short millisecond keep the run brief
   sfp_packer #(.DEPTH(8), .MS_CYCLES(20)) DUT (.*);
   sfp_net_sink net (.*);
   initial forever #2 REF_CLK = !REF_CLK;
   task automatic final_report;
      $display("errors %0d, checks %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : final_report
   task automatic chk(input string s, input logic [31:0] e, v);
      comparisons++;
      if (v !== e)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", s, e, v);
      end
   endtask : chk
   // every wait is bounded; a hang ends the run
   task automatic tick(inout int n);
      @(posedge REF_CLK);
      n++;
      if (n > 300) chk("timeout", 0, 1);
      if (n > 300) final_report();
   endtask : tick
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      S_AXI_AWVALID <= 1;
      S_AXI_WVALID <= 1;
      do
      begin
         tick(n);
         if (S_AXI_AWREADY) S_AXI_AWVALID <= 0;
         if (S_AXI_WREADY) S_AXI_WVALID <= 0;
      end while (!S_AXI_BVALID);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      int n = 0;
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1;
      do
      begin
         tick(n);
         if (S_AXI_ARREADY) S_AXI_ARVALID <= 0;
      end while (!S_AXI_RVALID);
      chk("register", e, S_AXI_RDATA);
   endtask : rd
   task automatic send(input logic [7:0] b[$]);
      int n = 0;
      foreach (b[i])
      begin
         RX_DATA <= b[i];
         RX_VALID <= 1;
         do tick(n); while (!RX_READY);
      end
      RX_VALID <= 0;
   endtask : send
   task automatic frame(input logic [7:0] e[$]);
      int n = 0;
      while (net.got.size() < e.size()) tick(n);
      while (!RX_READY) tick(n);
      chk("frame size", e.size(), net.got.size());
      foreach (e[i]) chk("frame byte", e[i], net.got[i]);
      net.got.delete();
   endtask : frame
   task automatic sess(input logic e);
      repeat (3) @(posedge REF_CLK);
      chk("session", e, SESSION_OPEN);
   endtask : sess
   // main sequence
   initial
   begin
      repeat (4) @(posedge REF_CLK);
      NRST <= 1;
      rd(8'h14, 32'h0fa1);
      sess(1);
      wr(8'h08, 3);
      send('{1, 2, 3, 4});
      frame('{1, 2, 3});
      wr(8'h08, 0);
      wr(8'h04, 32'h0a0d);
      wr(8'h00, 32'h104);
      send('{5, 8'h0d});
      frame('{4, 5, 8'h0d});
      wr(8'h00, 32'h10f);
      slow <= 1;
      send('{7, 8'h0d, 8'h0a});
      frame('{7});
      wr(8'h00, 32'h105);
      send('{8, 8'h0d, 9});
      frame('{8, 8'h0d, 9});
      wr(8'h00, 32'h108);
      send('{8'h0d, 1, 2, 3, 4, 5, 6, 7});
      frame('{8'h0d, 1, 2, 3, 4, 5, 6, 7});
      wr(8'h0c, 2);
      wr(8'h00, 32'hf80);
      chk("udp mode", 1, UDP_MODE);
      chk("sessions", 32'hf, TX_SESS);
      send('{6});
      frame('{6});
      wr(8'h0c, 0);
      wr(8'h00, 32'h130);
      sess(0);
      DSR <= 1;
      sess(1);
      DSR <= 0;
      sess(0);
      wr(8'h00, 32'h160);
      DCD <= 1;
      sess(1);
      DCD <= 0;
      sess(1);
      wr(8'h00, 32'h150);
      sess(0);
      wr(8'h00, 32'h140);
      DSR <= 1;
      sess(1);
      DSR <= 0;
      sess(1);
      wr(8'h10, 1);
      wr(8'h00, 32'h120);
      repeat (60) @(posedge REF_CLK);
      chk("session", 0, SESSION_OPEN);
      send('{3});
      sess(1);
      rd(8'h20, 0);
      chk("read resp", 3, S_AXI_RRESP);
      rd(8'h1c, 6);
      final_report();
   end
endmodule : testbench
